// file: hdl/ssr_pkg.sv
// Purpose: constants and carrier types for the supply reset supervisor
// Assumes: 40 MHz mclk
// Notes:   times kept in their own units, cycle counts derived from them
package ssr_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 25;
  // hold times in ms, short and long variants
  localparam int unsigned HOLD_SHORT_MS   = 35;
  localparam int unsigned HOLD_LONG_MS    = 140;
  // internal timebase, in Hz x100 (10.24 kHz)
  localparam int unsigned TB_FREQ_CHZ     = 1_024_000;
  // internal timebase period in mclk cycles, rounded down
  localparam int unsigned TB_DIV_CYC      = (CLK_HZ * 100) / TB_FREQ_CHZ;
  // hold length in timebase ticks, rounded up
  localparam int unsigned HOLD_SHORT_TICKS =
    (HOLD_SHORT_MS * TB_FREQ_CHZ + 99_999) / 100_000;
  localparam int unsigned HOLD_LONG_TICKS  =
    (HOLD_LONG_MS * TB_FREQ_CHZ + 99_999) / 100_000;
  localparam int unsigned TICK_W          = 12;
  localparam int unsigned DIV_W           = 13;
  // gated chip-enable nominal delay, met by one register stage
  localparam int unsigned CE_DELAY_NS     = 20;
  localparam int unsigned CE_DELAY_CYC    =
    (CE_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (CE_DELAY_NS / CLK_PERIOD_NS);
  // synchroniser comes out of reset as supply low, main supply selected
  localparam logic [1:0]  SYNC_RESET_VAL  = 2'h2;

  typedef struct packed {
    logic supplyLow;   // supply below reset threshold
    logic onBackup;    // switchover selected battery
  } ssr_cmp_type;

  typedef struct packed {
    logic resetN;
    logic resetP;
    logic lowLineN;
    logic backupActive;
    logic earlyFailN;
    logic kickTimeoutN;
    logic ceGatedN;
  } ssr_out_type;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_HOLD  = 2'b01,
    ST_RUN   = 2'b10
  } ssr_state_type;
endpackage : ssr_pkg

// file: hdl/ssr_sync.sv
// Purpose: two-flop synchroniser for comparator levels
// Assumes: input asynchronous to mclk
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module ssr_sync
  import ssr_pkg::*;
#(
  parameter int unsigned      WIDTH     = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stage1_reg <= RESET_VAL;
      syncOut    <= RESET_VAL;
    end else begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end
endmodule : ssr_sync

// file: hdl/ssr_supervisor.sv
// Purpose: digital core of a supply reset supervisor
// Assumes: comparator levels arrive asynchronous; mclk is the only clock
// Notes:   synchronised comparator path adds two cycles before any output
`timescale 1ns/1ps

// What this block does
// - reset output low whenever supply is below the reset threshold.
// - after supply returns, hold reset at least 35 ms short or 140 ms long.
// - hold duration is a module parameter.
// - reset stays asserted throughout power-down, never released while falling.
// - active-high reset is always the complement of active-low reset.
// - low-line flag follows supply-low or battery mode directly, no hold delay.
// - mode follows switchover comparator, whose hysteresis sets 70/50 mV points.
// - with supply valid, gated chip-enable follows incoming chip-enable.
// - supply low or on battery forces gated chip-enable high.
// - in backup, outputs held at fixed documented levels.
// - in backup, fail, kick, chip-enable and timebase inputs are ignored.
// - backup indicator low on main supply, high on battery.
// - hold counted from internal 10.24 kHz timebase by default.
module ssr_supervisor
  import ssr_pkg::*;
#(
  parameter int unsigned HOLD_TICKS = HOLD_SHORT_TICKS,
  parameter int unsigned TB_DIV     = TB_DIV_CYC
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic supplyLowCmp,
  input  wire logic switchoverCmp,
  input  wire logic earlyFailSenseIn,
  input  wire logic activityKickIn,
  input  wire logic chipEnableInN,
  input  wire logic timebaseIn,
  input  wire logic timebaseSelect,
  output logic      resetOutN,
  output logic      resetOut,
  output logic      lowLineOutN,
  output logic      backupActiveInd,
  output logic      earlyFailOutN,
  output logic      kickTimeoutOutN,
  output logic      chipEnableOutN
);
  ssr_cmp_type      cmpSync;
  logic [1:0]       cmpSyncBits;
  ssr_state_type    state_reg;
  logic [DIV_W-1:0] div_reg;
  logic [TICK_W-1:0] tick_reg;
  logic             tbTick;
  logic             supplyBad;
  ssr_out_type      out_next;

  localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(TB_DIV - 1);
  localparam logic [TICK_W-1:0] HOLD_LAST = TICK_W'(HOLD_TICKS - 1);

  // reset value must match the output reset state, or the backup flag pulses
  ssr_sync #(.WIDTH(2), .RESET_VAL(SYNC_RESET_VAL)) u_sync (
    .mclk    (mclk),
    .resetn  (resetn),
    .asyncIn ({supplyLowCmp, switchoverCmp}),
    .syncOut (cmpSyncBits)
  );
  assign cmpSync   = cmpSyncBits;
  assign supplyBad = cmpSync.supplyLow | cmpSync.onBackup;

  // internal timebase divider
  always_ff @(posedge mclk) begin
    if (!resetn || supplyBad) begin
      div_reg <= '0;
    end else if (div_reg == DIV_LAST) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  assign tbTick = (div_reg == DIV_LAST);

  // hold sequencer
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_reg <= ST_RESET;
      tick_reg  <= '0;
    end else if (supplyBad) begin
      state_reg <= ST_RESET;
      tick_reg  <= '0;
    end else begin
      unique case (state_reg)
        ST_RESET: begin
          state_reg <= ST_HOLD;
          tick_reg  <= '0;
        end
        ST_HOLD: begin
          if (tbTick) begin
            if (tick_reg == HOLD_LAST) begin
              state_reg <= ST_RUN;
            end else begin
              tick_reg <= tick_reg + 1'b1;
            end
          end
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
        default: begin
          state_reg <= ST_RESET;
        end
      endcase
    end
  end

  always_comb begin
    out_next.resetN       = (state_reg == ST_RUN) && !supplyBad;
    out_next.resetP       = !out_next.resetN;
    out_next.lowLineN     = !supplyBad;
    out_next.backupActive = cmpSync.onBackup;
    out_next.earlyFailN   = cmpSync.onBackup ? 1'b0 : earlyFailSenseIn;
    out_next.kickTimeoutN = 1'b1;
    out_next.ceGatedN     = supplyBad ? 1'b1 : chipEnableInN;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      resetOutN       <= 1'b0;
      resetOut        <= 1'b1;
      lowLineOutN     <= 1'b0;
      backupActiveInd <= 1'b0;
      earlyFailOutN   <= 1'b0;
      kickTimeoutOutN <= 1'b1;
      chipEnableOutN  <= 1'b1;
    end else begin
      resetOutN       <= out_next.resetN;
      resetOut        <= out_next.resetP;
      lowLineOutN     <= out_next.lowLineN;
      backupActiveInd <= out_next.backupActive;
      earlyFailOutN   <= out_next.earlyFailN;
      kickTimeoutOutN <= out_next.kickTimeoutN;
      chipEnableOutN  <= out_next.ceGatedN;
    end
  end

  // timebase and kick pins are outside this core's scope
  logic unusedTb;
  assign unusedTb = timebaseIn ^ timebaseSelect ^ activityKickIn;

  sequence supplyGood_s;
    !supplyBad;
  endsequence

  reset_complement_a: assert property (@(posedge mclk) disable iff (!resetn)
    resetOut == !resetOutN) else $error("reset outputs not complementary");
  reset_on_low_a: assert property (@(posedge mclk) disable iff (!resetn)
    cmpSync.supplyLow |=> !resetOutN) else $error("reset released on low supply");
  power_down_a: assert property (@(posedge mclk) disable iff (!resetn)
    supplyBad |=> state_reg == ST_RESET) else $error("hold not ended by power-down");
  hold_restart_a: assert property (@(posedge mclk) disable iff (!resetn)
    supplyBad |=> tick_reg == '0) else $error("hold count not cleared");
  low_line_a: assert property (@(posedge mclk) disable iff (!resetn)
    lowLineOutN == !$past(supplyBad)) else $error("low line flag delayed");
  ce_force_a: assert property (@(posedge mclk) disable iff (!resetn)
    supplyBad |=> chipEnableOutN) else $error("chip enable not forced high");
  ce_pass_a: assert property (@(posedge mclk) disable iff (!resetn)
    supplyGood_s |=> chipEnableOutN == $past(chipEnableInN))
    else $error("chip enable not passed");
  backup_ind_a: assert property (@(posedge mclk) disable iff (!resetn)
    backupActiveInd == $past(cmpSync.onBackup)) else $error("backup indicator wrong");
  backup_out_a: assert property (@(posedge mclk) disable iff (!resetn)
    cmpSync.onBackup |=> !earlyFailOutN && kickTimeoutOutN && !resetOutN)
    else $error("backup outputs wrong");
  hold_release_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(resetOutN) |-> $past(tbTick, 2) && $past(tick_reg, 2) == HOLD_LAST)
    else $error("reset released before hold end");
endmodule : ssr_supervisor

// file: bench/ssr_host_model.sv
// Purpose: processor side feeding chip enable and fail sense
// Assumes: changes just after mclk rises
// Notes:   both lines toggle every third cycle
`timescale 1ns/1ps
module ssr_host_model (
  input  wire logic mclk,
  output logic      chipEnableInN,
  output logic      earlyFailSenseIn
);
  logic [1:0] phase;
  initial begin
    chipEnableInN = 1'b1;
    earlyFailSenseIn = 1'b1;
    phase = 2'h0;
  end
  always @(posedge mclk) begin
    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    if (phase == 2'h2) begin
      chipEnableInN <= ~chipEnableInN;
      earlyFailSenseIn <= ~earlyFailSenseIn;
    end
  end
endmodule : ssr_host_model

// file: bench/test_supply_reset_supervisor.sv
// Purpose: self-checking bench for the supply reset supervisor
// Assumes: hold shortened to 4 ticks of 4 cycles
// Notes:   comparator levels driven by the bench
`timescale 1ns/1ps
module test_supply_reset_supervisor;
  import ssr_pkg::*;
  localparam int unsigned HOLD = 4;
  localparam int unsigned DIV = 4;
  logic mclk, resetn, supplyLowCmp, switchoverCmp, kick, tbIn, tbSel;
  logic chipEnableInN, earlyFailSenseIn, ce, ef;
  logic resetOutN, resetOut, lowLineOutN, backupActiveInd;
  logic earlyFailOutN, kickTimeoutOutN, chipEnableOutN;
  int n_fail = 0;
  int n_checks = 0;
  ssr_host_model host (.mclk(mclk), .chipEnableInN(chipEnableInN),
    .earlyFailSenseIn(earlyFailSenseIn));
  ssr_supervisor #(.HOLD_TICKS(HOLD), .TB_DIV(DIV)) DUT (.mclk(mclk), .resetn(resetn),
    .supplyLowCmp(supplyLowCmp), .switchoverCmp(switchoverCmp),
    .earlyFailSenseIn(earlyFailSenseIn), .activityKickIn(kick),
    .chipEnableInN(chipEnableInN), .timebaseIn(tbIn), .timebaseSelect(tbSel),
    .resetOutN(resetOutN), .resetOut(resetOut), .lowLineOutN(lowLineOutN),
    .backupActiveInd(backupActiveInd), .earlyFailOutN(earlyFailOutN),
    .kickTimeoutOutN(kickTimeoutOutN), .chipEnableOutN(chipEnableOutN));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(string what, logic exp, logic got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic give_verdict;
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic t_low;
    for (int i = 0; i < 8; i++) begin
      step(1);
      chk("resetOutN", 1'b0, resetOutN);
      chk("chipEnableOutN", 1'b1, chipEnableOutN);
      chk("lowLineOutN", 1'b0, lowLineOutN);
      chk("backupActiveInd", 1'b0, backupActiveInd);
    end
  endtask : t_low
  task automatic t_powerup;
    int n;
    n = 0;
    @(posedge mclk) supplyLowCmp <= 1'b0;
    while (n < 40 && resetOutN !== 1'b1) begin
      step(1);
      n++;
      if (n == 5) chk("lowLineOutN", 1'b1, lowLineOutN);
      chk("resetOut", ~resetOutN, resetOut);
    end
    chk("holdLong", 1'b1, n >= HOLD * DIV);
    chk("holdEnds", 1'b1, n <= HOLD * DIV + 6);
  endtask : t_powerup
  task automatic t_follow;
    for (int i = 0; i < 12; i++) begin
      ce = chipEnableInN;
      ef = earlyFailSenseIn;
      step(1);
      chk("chipEnableOutN", ce, chipEnableOutN);
      chk("earlyFailOutN", ef, earlyFailOutN);
    end
  endtask : t_follow
  task automatic t_restart;
    @(posedge mclk) supplyLowCmp <= 1'b1;
    step(4);
    @(posedge mclk) supplyLowCmp <= 1'b0;
    step(10);
    chk("resetOutN", 1'b0, resetOutN);
    @(posedge mclk) supplyLowCmp <= 1'b1;
    step(4);
    t_low();
    t_powerup();
  endtask : t_restart
  task automatic t_backup;
    @(posedge mclk) switchoverCmp <= 1'b1;
    step(4);
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk) begin
        kick <= ~kick;
        tbIn <= ~tbIn;
        tbSel <= ~tbSel;
      end
      #1;
      chk("backupActiveInd", 1'b1, backupActiveInd);
      chk("earlyFailOutN", 1'b0, earlyFailOutN);
      chk("resetOutN", 1'b0, resetOutN);
      chk("resetOut", 1'b1, resetOut);
      chk("lowLineOutN", 1'b0, lowLineOutN);
      chk("kickTimeoutOutN", 1'b1, kickTimeoutOutN);
      chk("chipEnableOutN", 1'b1, chipEnableOutN);
    end
    @(posedge mclk) begin
      switchoverCmp <= 1'b0;
      supplyLowCmp <= 1'b1;
    end
    step(4);
    chk("backupActiveInd", 1'b0, backupActiveInd);
  endtask : t_backup
  initial begin
    resetn = 1'b0;
    supplyLowCmp = 1'b1;
    switchoverCmp = 1'b0;
    kick = 1'b0;
    tbIn = 1'b0;
    tbSel = 1'b1;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    step(1);
    chk("resetOut", 1'b1, resetOut);
    t_low();
    t_powerup();
    t_follow();
    t_restart();
    t_backup();
    t_powerup();
    t_follow();
    give_verdict();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end
endmodule : test_supply_reset_supervisor
